// file: src/processor_status_consts.svh
`ifndef PROCESSOR_STATUS_CONSTS_SVH
`define PROCESSOR_STATUS_CONSTS_SVH

// Register numbers.
`define PS_BOOT_STATUS 8'h03
`define PS_SECURITY_CONFIG 8'h05
`define PS_RING_OSC_CONTROL 8'h06
`define PS_RING_OSC_TILE_CELL 8'h07
`define PS_RING_OSC_TILE_WIRE 8'h08
`define PS_RING_OSC_PERIPH_CELL 8'h09
`define PS_RING_OSC_PERIPH_WIRE 8'h0a
`define PS_RAM_SIZE 8'h0c
`define PS_DEBUG_SAVED_STATUS 8'h10
`define PS_DEBUG_SAVED_PC 8'h11
`define PS_DEBUG_SAVED_SP 8'h12
`define PS_DEBUG_READ_THREAD_SEL 8'h13
`define PS_DEBUG_READ_REG_SEL 8'h14

// Boot status field positions.
`define BOOT_PROC_NUM_LSB 16
`define BOOT_OVERRIDE_BIT 8
`define BOOT_CORE1_OFF_BIT 5
`define BOOT_SKIP_OTP_POLL_BIT 4
`define BOOT_FROM_RAM_BIT 3
`define BOOT_FROM_JTAG_BIT 2

// Security configuration fields.
`define SEC_WRITE_LOCK_BIT 31
`define SEC_GLOBAL_DEBUG_OFF_BIT 14
`define SEC_OTP_LOCK_ALL_BIT 12
`define SEC_OTP_SECTOR_LOCK_LSB 8
`define SEC_OTP_REDUNDANCY_BIT 7
`define SEC_BOOT_FROM_OTP_BIT 5
`define SEC_JTAG_CFG_OFF_BIT 4
`define SEC_JTAG_TAP_OFF_BIT 0
`define SEC_WRITABLE_MASK 32'h8000_5fb1

// Ring oscillator control fields and reset.
`define ROSC_CORE_EN_BIT 1
`define ROSC_PERIPH_EN_BIT 0
`define ROSC_CONTROL_RESET 2'h0
`define ROSC_STOP_SETTLE_CYCLES 10

// Saved status snapshot: writable bits and the read-only issue mode bit.
`define SSR_DEBUG_WRITABLE_MASK 32'h0000_06df
`define SSR_ISSUE_MODE_BIT 8

// Debug register read operand widths.
`define DGR_THREAD_MASK 32'h0000_00ff
`define DGR_REG_MASK 32'h0000_001f

`endif

// file: src/processor_status_pkg.sv
package processor_status_pkg;
    typedef logic [31:0] ps_word_t;
    typedef logic [7:0] ps_reg_num_t;
    typedef logic [15:0] rosc_count_t;
    typedef logic [31:0] ram_size_t;
endpackage

// file: src/processor_status_regs.sv
`timescale 1ns/100ps
`include "processor_status_consts.svh"

module processor_status_regs (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Processor-status instruction port.
    input wire logic ps_write,
    input wire logic ps_read,
    input wire processor_status_pkg::ps_reg_num_t ps_addr,
    input wire processor_status_pkg::ps_word_t ps_wdata,
    input wire logic debug_mode,
    output processor_status_pkg::ps_word_t ps_rdata,
    output logic ps_rvalid,
    output logic ps_write_refused,
    // Boot straps and tile information.
    input wire logic [7:0] processor_number,
    input wire logic boot_override,
    input wire logic core1_powered_off,
    input wire logic skip_otp_poll,
    input wire logic boot_from_ram,
    input wire logic boot_from_jtag,
    input wire logic [1:0] boot_pll_mode_pins,
    input wire processor_status_pkg::ram_size_t ram_size_bytes,
    // OTP security word load.
    input wire logic otp_security_load,
    input wire processor_status_pkg::ps_word_t otp_security_word,
    // Debugger entry snapshot and the live dual-issue flag.
    input wire logic debug_entry,
    input wire processor_status_pkg::ps_word_t saved_status_word,
    input wire processor_status_pkg::ps_word_t saved_program_counter,
    input wire processor_status_pkg::ps_word_t saved_stack_pointer,
    input wire logic current_dual_issue_flag,
    // Ring oscillator counts, each counter in its own oscillator domain.
    input wire processor_status_pkg::rosc_count_t rosc_count_in [4],
    // Security controls and oscillator enables.
    output logic global_debug_disable,
    output logic jtag_tap_disable,
    output logic otp_lock_all,
    output logic [3:0] otp_sector_lock,
    output logic otp_redundancy_enable,
    output logic boot_from_otp,
    output logic jtag_config_disable,
    output logic rosc_core_enable,
    output logic rosc_periph_enable,
    // Debug register read operands.
    output logic [7:0] debug_thread_reg_read_thread,
    output logic [4:0] debug_thread_reg_read_reg
);
    import processor_status_pkg::*;

    ps_word_t security_config;
    logic [1:0] ring_osc_control;
    ps_word_t debug_saved_status;
    ps_word_t debug_saved_pc;
    ps_word_t debug_saved_sp;
    logic [7:0] debug_read_thread_sel;
    logic [4:0] debug_read_reg_sel;
    rosc_count_t rosc_meta [4];
    rosc_count_t rosc_sync [4];
    ps_word_t next_rdata;
    logic dbg_wr;
    logic sec_wr;

    assign dbg_wr = ps_write && debug_mode;
    assign sec_wr = ps_write && (ps_addr == `PS_SECURITY_CONFIG);

    // Security word: OTP load always wins; software writes only while unlocked.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            security_config <= 32'h0000_0000;
        end else if (otp_security_load) begin
            security_config <= otp_security_word & `SEC_WRITABLE_MASK;
        end else if (sec_wr && !security_config[`SEC_WRITE_LOCK_BIT]) begin
            security_config <= ps_wdata & `SEC_WRITABLE_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ps_write_refused <= 1'b0;
        end else begin
            ps_write_refused <= sec_wr && security_config[`SEC_WRITE_LOCK_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            global_debug_disable <= 1'b0;
            jtag_tap_disable <= 1'b0;
            otp_lock_all <= 1'b0;
            otp_sector_lock <= 4'h0;
            otp_redundancy_enable <= 1'b0;
            boot_from_otp <= 1'b0;
            jtag_config_disable <= 1'b0;
        end else begin
            global_debug_disable <= security_config[`SEC_GLOBAL_DEBUG_OFF_BIT];
            jtag_tap_disable <= security_config[`SEC_JTAG_TAP_OFF_BIT];
            otp_lock_all <= security_config[`SEC_OTP_LOCK_ALL_BIT];
            otp_sector_lock <= security_config[`SEC_OTP_SECTOR_LOCK_LSB +: 4];
            otp_redundancy_enable <= security_config[`SEC_OTP_REDUNDANCY_BIT];
            boot_from_otp <= security_config[`SEC_BOOT_FROM_OTP_BIT];
            jtag_config_disable <= security_config[`SEC_JTAG_CFG_OFF_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ring_osc_control <= `ROSC_CONTROL_RESET;
        end else if (ps_write && ps_addr == `PS_RING_OSC_CONTROL) begin
            ring_osc_control <= ps_wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rosc_core_enable <= 1'b0;
            rosc_periph_enable <= 1'b0;
        end else begin
            rosc_core_enable <= ring_osc_control[`ROSC_CORE_EN_BIT];
            rosc_periph_enable <= ring_osc_control[`ROSC_PERIPH_EN_BIT];
        end
    end

    // The counts come from free-running oscillators, so a running count may be
    // caught mid-change; software waits for the settle time after stopping.
    // The synchronisers take no reset so the counts survive a system reset.
    generate
        for (genvar i = 0; i < 4; i++) begin : g_rosc
            always_ff @(posedge sys_clk) begin
                rosc_meta[i] <= rosc_count_in[i];
                rosc_sync[i] <= rosc_meta[i];
            end
        end
    endgenerate

    // Snapshot registers: debugger entry overrides a concurrent debug write.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            debug_saved_status <= 32'h0000_0000;
        end else if (debug_entry) begin
            debug_saved_status <= saved_status_word & `SSR_DEBUG_WRITABLE_MASK;
        end else if (dbg_wr && ps_addr == `PS_DEBUG_SAVED_STATUS) begin
            debug_saved_status <= ps_wdata & `SSR_DEBUG_WRITABLE_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            debug_saved_pc <= 32'h0000_0000;
            debug_saved_sp <= 32'h0000_0000;
        end else if (debug_entry) begin
            debug_saved_pc <= saved_program_counter;
            debug_saved_sp <= saved_stack_pointer;
        end else if (dbg_wr && ps_addr == `PS_DEBUG_SAVED_PC) begin
            debug_saved_pc <= ps_wdata;
        end else if (dbg_wr && ps_addr == `PS_DEBUG_SAVED_SP) begin
            debug_saved_sp <= ps_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            debug_read_thread_sel <= 8'h00;
            debug_read_reg_sel <= 5'h00;
        end else if (dbg_wr && ps_addr == `PS_DEBUG_READ_THREAD_SEL) begin
            debug_read_thread_sel <= ps_wdata[7:0];
        end else if (dbg_wr && ps_addr == `PS_DEBUG_READ_REG_SEL) begin
            debug_read_reg_sel <= ps_wdata[4:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            debug_thread_reg_read_thread <= 8'h00;
            debug_thread_reg_read_reg <= 5'h00;
        end else begin
            debug_thread_reg_read_thread <= debug_read_thread_sel;
            debug_thread_reg_read_reg <= debug_read_reg_sel;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (ps_addr)
            `PS_BOOT_STATUS: begin
                next_rdata[`BOOT_PROC_NUM_LSB +: 8] = processor_number;
                next_rdata[`BOOT_OVERRIDE_BIT] = boot_override;
                next_rdata[`BOOT_CORE1_OFF_BIT] = core1_powered_off;
                next_rdata[`BOOT_SKIP_OTP_POLL_BIT] = skip_otp_poll;
                next_rdata[`BOOT_FROM_RAM_BIT] = boot_from_ram;
                next_rdata[`BOOT_FROM_JTAG_BIT] = boot_from_jtag;
                next_rdata[1:0] = boot_pll_mode_pins;
            end
            `PS_SECURITY_CONFIG: next_rdata = security_config;
            `PS_RING_OSC_CONTROL: next_rdata[1:0] = ring_osc_control;
            `PS_RING_OSC_TILE_CELL: next_rdata[15:0] = rosc_sync[0];
            `PS_RING_OSC_TILE_WIRE: next_rdata[15:0] = rosc_sync[1];
            `PS_RING_OSC_PERIPH_CELL: next_rdata[15:0] = rosc_sync[2];
            `PS_RING_OSC_PERIPH_WIRE: next_rdata[15:0] = rosc_sync[3];
            `PS_RAM_SIZE: next_rdata = {ram_size_bytes[31:2], 2'b00};
            `PS_DEBUG_SAVED_STATUS: begin
                next_rdata = debug_saved_status;
                next_rdata[`SSR_ISSUE_MODE_BIT] = current_dual_issue_flag;
            end
            `PS_DEBUG_SAVED_PC: next_rdata = debug_saved_pc;
            `PS_DEBUG_SAVED_SP: next_rdata = debug_saved_sp;
            `PS_DEBUG_READ_THREAD_SEL: next_rdata[7:0] = debug_read_thread_sel;
            `PS_DEBUG_READ_REG_SEL: next_rdata[4:0] = debug_read_reg_sel;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ps_rdata <= 32'h0000_0000;
            ps_rvalid <= 1'b0;
        end else begin
            ps_rvalid <= ps_read;
            if (ps_read) begin
                ps_rdata <= next_rdata;
            end
        end
    end
endmodule

// file: tb/processor_status_regs_sva.sv
`timescale 1ns/100ps
`include "processor_status_consts.svh"

module processor_status_regs_chk (
    // Watched ports.
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ps_write,
    input wire logic ps_read,
    input wire processor_status_pkg::ps_reg_num_t ps_addr,
    input wire processor_status_pkg::ps_word_t ps_wdata,
    input wire processor_status_pkg::ps_word_t ps_rdata,
    input wire logic debug_mode,
    input wire logic ps_rvalid,
    input wire logic ps_write_refused,
    input wire logic otp_security_load,
    input wire processor_status_pkg::ps_word_t otp_security_word,
    input wire logic global_debug_disable,
    input wire logic rosc_core_enable,
    input wire logic rosc_periph_enable,
    input wire logic [7:0] debug_thread_reg_read_thread,
    input wire logic [4:0] debug_thread_reg_read_reg
);
    import processor_status_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_rvalid; ps_read |=> ps_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_no_rvalid; !ps_read |=> !ps_rvalid; endproperty
    a_no_rvalid: assert property (p_no_rvalid) else $error("stray read answer");
    property p_refused;
        ps_write_refused |-> $past(ps_write) && $past(ps_addr) == `PS_SECURITY_CONFIG;
    endproperty
    a_refused: assert property (p_refused) else $error("refusal without write");
    property p_ctl;
        ps_write && ps_addr == `PS_RING_OSC_CONTROL
            |-> ##2 {rosc_core_enable, rosc_periph_enable} == $past(ps_wdata[1:0], 2);
    endproperty
    a_ctl: assert property (p_ctl) else $error("oscillator enables wrong");
    property p_thread;
        ps_write && debug_mode && ps_addr == `PS_DEBUG_READ_THREAD_SEL
            |-> ##2 debug_thread_reg_read_thread == $past(ps_wdata[7:0], 2);
    endproperty
    a_thread: assert property (p_thread) else $error("thread operand wrong");
    property p_reg_locked;
        ps_write && !debug_mode && ps_addr == `PS_DEBUG_READ_REG_SEL
            |=> ##1 $stable(debug_thread_reg_read_reg);
    endproperty
    a_reg_locked: assert property (p_reg_locked) else $error("operand written outside debug");
    property p_load;
        otp_security_load |-> ##2 global_debug_disable == $past(otp_security_word[14], 2);
    endproperty
    a_load: assert property (p_load) else $error("security load not applied");
    property p_reset;
        disable iff (1'b0) rst |=> !rosc_core_enable && !rosc_periph_enable;
    endproperty
    a_reset: assert property (p_reset) else $error("enables not cleared");
    property p_unmapped; ps_read && ps_addr == 8'h0b |=> ps_rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

bind processor_status_regs processor_status_regs_chk processor_status_regs_chk_i (
    .sys_clk, .rst, .ps_write, .ps_read, .ps_addr, .ps_wdata, .ps_rdata, .debug_mode,
    .ps_rvalid, .ps_write_refused, .otp_security_load, .otp_security_word,
    .global_debug_disable, .rosc_core_enable, .rosc_periph_enable,
    .debug_thread_reg_read_thread, .debug_thread_reg_read_reg
);

// file: tb/tb_top.sv
`timescale 1ns/100ps
`include "processor_status_consts.svh"

module tb_top;
    import processor_status_pkg::*;
    logic sys_clk, rst = 1'b1, ps_write = 1'b0, ps_read = 1'b0, debug_mode = 1'b0;
    logic otp_security_load = 1'b0, debug_entry = 1'b0, current_dual_issue_flag = 1'b0;
    logic ps_rvalid, ps_write_refused;
    logic [15:0] straps = 16'h5aa9;
    ps_reg_num_t ps_addr = 8'h00;
    ps_word_t ps_wdata = 32'h0, otp_security_word = 32'h0, ram_size_bytes = 32'h0004_0000;
    ps_word_t saved_status_word = '1, saved_program_counter = '1, saved_stack_pointer = '1;
    ps_word_t ps_rdata, dbg_exp [5];
    rosc_count_t rosc_count_in [4] = '{16'h1357, 16'h2468, 16'hace1, 16'hbdf2};
    wire [9:0] sec_out;
    wire [1:0] rosc_en;
    logic [7:0] debug_thread_reg_read_thread;
    logic [4:0] debug_thread_reg_read_reg;
    int errors = 0, total_checks = 0;

    processor_status_regs processor_status_regs_i (
        .sys_clk, .rst, .ps_write, .ps_read, .ps_addr, .ps_wdata, .debug_mode, .ps_rdata,
        .ps_rvalid, .ps_write_refused, .processor_number(straps[15:8]),
        .boot_override(straps[7]), .core1_powered_off(straps[6]), .skip_otp_poll(straps[5]),
        .boot_from_ram(straps[4]), .boot_from_jtag(straps[3]), .boot_pll_mode_pins(straps[1:0]),
        .ram_size_bytes, .otp_security_load, .otp_security_word, .debug_entry,
        .saved_status_word, .saved_program_counter, .saved_stack_pointer,
        .current_dual_issue_flag, .rosc_count_in, .global_debug_disable(sec_out[9]),
        .jtag_tap_disable(sec_out[8]), .otp_lock_all(sec_out[7]), .otp_sector_lock(sec_out[6:3]),
        .otp_redundancy_enable(sec_out[2]), .boot_from_otp(sec_out[1]),
        .jtag_config_disable(sec_out[0]), .rosc_core_enable(rosc_en[1]),
        .rosc_periph_enable(rosc_en[0]), .debug_thread_reg_read_thread, .debug_thread_reg_read_reg
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task chk(input string n, input ps_word_t e, input ps_word_t g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // Each access starts one falling edge later, so no signal is driven twice at once.
    task wr(input ps_reg_num_t a, input ps_word_t d);
        @(negedge sys_clk);
        ps_addr = a;
        ps_wdata = d;
        ps_write = 1'b1;
        @(negedge sys_clk);
        ps_write = 1'b0;
    endtask

    task rd(input ps_reg_num_t a, input ps_word_t e);
        @(negedge sys_clk);
        ps_addr = a;
        ps_read = 1'b1;
        @(negedge sys_clk);
        ps_read = 1'b0;
        chk("rvalid", 32'h1, {31'h0, ps_rvalid});
        chk("rdata", e, ps_rdata);
    endtask

    // The read also gives the two cycles the decoded controls need to follow.
    task sec(input ps_word_t w);
        rd(`PS_SECURITY_CONFIG, w & `SEC_WRITABLE_MASK);
        chk("sec_out", {22'h0, w[14], w[0], w[12], w[11:8], w[7], w[5], w[4]}, {22'h0, sec_out});
    endtask

    task load(input ps_word_t w);
        @(negedge sys_clk);
        otp_security_word = w;
        otp_security_load = 1'b1;
        @(negedge sys_clk);
        otp_security_load = 1'b0;
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #100us;
        errors++;
        finish_test;
    end

    initial begin
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        chk("rst_out", 32'h0, {7'h0, sec_out, rosc_en, debug_thread_reg_read_thread,
            debug_thread_reg_read_reg});
        for (int p = 0; p < 2; p++) begin
            straps = p ? 16'ha556 : 16'h5aa9;
            rd(`PS_BOOT_STATUS, {8'h0, straps[15:8], 7'h0, straps[7], 2'h0, straps[6:3],
                straps[1:0]});
        end
        wr(`PS_RAM_SIZE, 32'h0);
        rd(`PS_RAM_SIZE, {ram_size_bytes[31:2], 2'b00});
        rd(8'h0b, 32'h0);
        $display("test straps done");
        wr(`PS_RING_OSC_CONTROL, 32'h0);
        repeat (`ROSC_STOP_SETTLE_CYCLES) @(negedge sys_clk);
        for (int i = 0; i < 4; i++) rd(`PS_RING_OSC_TILE_CELL + 8'(i), {16'h0, rosc_count_in[i]});
        wr(`PS_RING_OSC_CONTROL, 32'hffff_ffff);
        rd(`PS_RING_OSC_CONTROL, 32'h3);
        chk("rosc_en", 32'h3, {30'h0, rosc_en});
        wr(`PS_RING_OSC_CONTROL, 32'h2);
        rd(`PS_RING_OSC_CONTROL, 32'h2);
        chk("rosc_en", 32'h2, {30'h0, rosc_en});
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        rd(`PS_RING_OSC_CONTROL, 32'h0);
        rd(`PS_RING_OSC_TILE_CELL, {16'h0, rosc_count_in[0]});
        $display("test oscillators done");
        load(32'hffff_ffff);
        sec(32'hffff_ffff);
        load(32'h0);
        sec(32'h0);
        wr(`PS_SECURITY_CONFIG, 32'h0000_0a10);
        sec(32'h0000_0a10);
        wr(`PS_SECURITY_CONFIG, 32'h8000_50a1);
        sec(32'h8000_50a1);
        wr(`PS_SECURITY_CONFIG, 32'h0);
        chk("refused", 32'h1, {31'h0, ps_write_refused});
        sec(32'h8000_50a1);
        load(32'h0);
        sec(32'h0);
        $display("test security done");
        debug_mode = 1'b1;
        wr(`PS_DEBUG_READ_THREAD_SEL, 32'hffff_ffff);
        wr(`PS_DEBUG_READ_REG_SEL, 32'hffff_ffff);
        @(negedge sys_clk);
        debug_entry = 1'b1;
        @(negedge sys_clk);
        debug_entry = 1'b0;
        debug_mode = 1'b0;
        current_dual_issue_flag = 1'b1;
        dbg_exp = '{`SSR_DEBUG_WRITABLE_MASK | 32'h100, '1, '1, 32'hff, 32'h1f};
        for (int i = 0; i < 5; i++) begin
            wr(`PS_DEBUG_SAVED_STATUS + 8'(i), 32'h0);
            rd(`PS_DEBUG_SAVED_STATUS + 8'(i), dbg_exp[i]);
        end
        chk("operands", 32'h1fff, {19'h0, debug_thread_reg_read_thread,
            debug_thread_reg_read_reg});
        debug_mode = 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(`PS_DEBUG_SAVED_STATUS + 8'(i), 32'h0);
            rd(`PS_DEBUG_SAVED_STATUS + 8'(i), (i == 0) ? 32'h100 : 32'h0);
        end
        chk("operands", 32'h0, {19'h0, debug_thread_reg_read_thread,
            debug_thread_reg_read_reg});
        $display("test debug done");
        finish_test;
    end
endmodule
